// [nvm_regs_pkg.sv]
// Package with register map, field positions and shared types of the memory protection block.
package nvm_regs_pkg;

   // Register indices; each register takes one word, so its byte address is four times its index.
   localparam int protect_idx     = 1;
   localparam int status_idx      = 2;
   localparam int int_enable_idx  = 3;
   localparam int int_flag_idx    = 4;
   localparam int data_idx        = 6;
   localparam int addr_idx        = 8;

   localparam logic [11:0] protect_off     = 12'(protect_idx * 4);
   localparam logic [11:0] status_off      = 12'(status_idx * 4);
   localparam logic [11:0] int_enable_off  = 12'(int_enable_idx * 4);
   localparam logic [11:0] int_flag_off    = 12'(int_flag_idx * 4);
   localparam logic [11:0] data_off        = 12'(data_idx * 4);
   localparam logic [11:0] addr_off        = 12'(addr_idx * 4);

   localparam int app_wp_bit      = 0;
   localparam int boot_lock_bit   = 1;
   localparam int flash_busy_bit  = 0;
   localparam int ee_busy_bit     = 1;
   localparam int write_fault_bit = 2;
   localparam int ee_ready_bit    = 0;

   localparam logic [7:0]  reg8_reset  = 8'h00;
   localparam logic [15:0] reg16_reset = 16'h0000;

   // Status reported by the memory arrays.
   typedef struct packed {
      logic flash_busy;
      logic eeprom_busy;
      logic op_done;
      logic op_error;
   } mem_status_s;

   // Boot section access from the core.
   typedef struct packed {
      logic in_boot;
      logic boot_read;
      logic boot_fetch;
   } boot_access_s;

endpackage

// [nvm_boot_guard.sv]
// Boot section lock holder with deferred activation and read masking.
`timescale 1ns/1ps
`default_nettype none
module nvm_boot_guard
(
   input  wire logic  pclk,
   input  wire logic  presetn,
   input  wire logic  lock_write,
   input  wire logic  in_boot,
   input  wire logic  read_hit,
   input  wire logic  [15:0] raw_data,
   output logic       lock_armed,
   output logic       lock_active,
   output logic       [15:0] masked_data
);

   logic in_boot_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         in_boot_q <= 1'b0;
      else
         in_boot_q <= in_boot;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lock_armed <= 1'b0;
      else if (lock_write && in_boot)
         lock_armed <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lock_active <= 1'b0;
      else if (lock_armed && in_boot_q && !in_boot)
         lock_active <= 1'b1;
   end

   always_comb
   begin
      masked_data = (lock_active && read_hit) ? 16'h0000 : raw_data;
   end

endmodule
`default_nettype wire

// [nvm_protect_status_regs.sv]
// Protection, status, interrupt and data/address registers of the memory controller on APB.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module nvm_protect_status_regs
(
   input  wire logic  pclk,
   input  wire logic  presetn,
   input  wire logic  psel,
   input  wire logic  penable,
   input  wire logic  pwrite,
   input  wire logic  [11:0] paddr,
   input  wire logic  [31:0] pwdata,
   input  wire logic  [3:0] pstrb,
   output logic       [31:0] prdata,
   output logic       pready,
   output logic       pslverr,
   input  wire nvm_regs_pkg::mem_status_s  mem_status,
   input  wire nvm_regs_pkg::boot_access_s boot_access,
   input  wire logic  app_write_req,
   input  wire logic  [15:0] app_write_addr,
   input  wire logic  [15:0] boot_raw_data,
   output logic       [15:0] boot_read_data,
   output logic       app_write_block,
   output logic       eeprom_ready_irq
);

   logic        app_wp_q;
   logic        write_fault_q;
   logic        ee_ready_en_q;
   logic        ee_ready_flag_q;
   logic        ee_busy_q;
   logic        flash_busy_q;
   logic [15:0] data_q;
   logic [15:0] addr_q;
   logic [15:0] boot_data_q;
   logic        block_q;
   logic        irq_q;
   logic        lock_armed;
   logic        lock_active;
   logic [15:0] masked_data;
   logic        wr_en;
   logic        rd_en;
   logic        lock_write;
   logic        boot_hit;
   logic [31:0] rdata_d;
   logic        hit_d;

   // Decides whether an offset belongs to the map.
   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == nvm_regs_pkg::protect_off) || (a == nvm_regs_pkg::status_off) ||
               (a == nvm_regs_pkg::int_enable_off) || (a == nvm_regs_pkg::int_flag_off) ||
               (a == nvm_regs_pkg::data_off) || (a == nvm_regs_pkg::addr_off);
   endfunction

   assign wr_en      = psel && penable && pwrite && pready;
   assign rd_en      = psel && !penable && !pwrite;
   assign lock_write = wr_en && pstrb[0] && (paddr == nvm_regs_pkg::protect_off) &&
                       pwdata[nvm_regs_pkg::boot_lock_bit];
   assign boot_hit   = boot_access.boot_read || boot_access.boot_fetch;

   nvm_boot_guard guard
   (
      .pclk        (pclk),
      .presetn     (presetn),
      .lock_write  (lock_write),
      .in_boot     (boot_access.in_boot),
      .read_hit    (boot_hit),
      .raw_data    (boot_raw_data),
      .lock_armed  (lock_armed),
      .lock_active (lock_active),
      .masked_data (masked_data)
   );

   // No wait state: setup registers the answer, access completes.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped(paddr);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         app_wp_q <= 1'b0;
      else if (wr_en && pstrb[0] && paddr == nvm_regs_pkg::protect_off &&
               pwdata[nvm_regs_pkg::app_wp_bit])
         app_wp_q <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         write_fault_q <= 1'b0;
      else if (mem_status.op_done)
         write_fault_q <= mem_status.op_error;
      else if (app_write_req)
         write_fault_q <= app_wp_q;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ee_busy_q    <= 1'b0;
         flash_busy_q <= 1'b0;
      end
      else
      begin
         ee_busy_q    <= mem_status.eeprom_busy;
         flash_busy_q <= mem_status.flash_busy;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ee_ready_en_q <= 1'b0;
      else if (wr_en && pstrb[0] && paddr == nvm_regs_pkg::int_enable_off)
         ee_ready_en_q <= pwdata[nvm_regs_pkg::ee_ready_bit];
   end

   // ready flag, set wins over clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ee_ready_flag_q <= 1'b0;
      else if (!mem_status.eeprom_busy)
         ee_ready_flag_q <= 1'b1;
      else if (wr_en && pstrb[0] && paddr == nvm_regs_pkg::int_flag_off &&
               pwdata[nvm_regs_pkg::ee_ready_bit])
         ee_ready_flag_q <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         data_q <= nvm_regs_pkg::reg16_reset;
      else if (wr_en && paddr == nvm_regs_pkg::data_off)
      begin
         if (pstrb[0])
            data_q[7:0] <= pwdata[7:0];
         if (pstrb[1])
            data_q[15:8] <= pwdata[15:8];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         addr_q <= nvm_regs_pkg::reg16_reset;
      else if (wr_en && paddr == nvm_regs_pkg::addr_off)
      begin
         if (pstrb[0])
            addr_q[7:0] <= pwdata[7:0];
         if (pstrb[1])
            addr_q[15:8] <= pwdata[15:8];
      end
      else if (app_write_req && !app_wp_q)
         addr_q <= app_write_addr;
   end

   // read mux with unused bits zero
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      hit_d   = 1'b1;
      case (paddr)
         nvm_regs_pkg::protect_off:
         begin
            rdata_d[nvm_regs_pkg::app_wp_bit]    = app_wp_q;
            rdata_d[nvm_regs_pkg::boot_lock_bit] = lock_armed;
         end
         nvm_regs_pkg::status_off:
         begin
            rdata_d[nvm_regs_pkg::flash_busy_bit]  = flash_busy_q;
            rdata_d[nvm_regs_pkg::ee_busy_bit]     = ee_busy_q;
            rdata_d[nvm_regs_pkg::write_fault_bit] = write_fault_q;
         end
         nvm_regs_pkg::int_enable_off:
            rdata_d[nvm_regs_pkg::ee_ready_bit] = ee_ready_en_q;
         nvm_regs_pkg::int_flag_off:
            rdata_d[nvm_regs_pkg::ee_ready_bit] = ee_ready_flag_q;
         nvm_regs_pkg::data_off:
            rdata_d[15:0] = data_q;
         nvm_regs_pkg::addr_off:
            rdata_d[15:0] = addr_q;
         default:
            hit_d = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_en)
         prdata <= hit_d ? rdata_d : 32'h0000_0000;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         boot_data_q <= nvm_regs_pkg::reg16_reset;
      else
         boot_data_q <= masked_data;
   end

   assign boot_read_data = boot_data_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         block_q <= 1'b0;
      else
         block_q <= app_wp_q;
   end

   assign app_write_block = block_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_q <= 1'b0;
      else
         irq_q <= ee_ready_en_q && ee_ready_flag_q;
   end

   assign eeprom_ready_irq = irq_q;

   // Assertions.
   sticky_protect_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(app_wp_q) |-> app_wp_q [*8])
      else $error("write protect dropped");
   protect_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      app_wp_q |=> app_write_block)
      else $error("protect not forwarded");
   lock_from_boot_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(lock_armed) |-> $past(boot_access.in_boot))
      else $error("lock set outside boot");
   lock_deferred_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(lock_active) |-> $past(boot_access.in_boot, 2) && !$past(boot_access.in_boot))
      else $error("lock activated early");
   boot_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      (lock_active && boot_hit) |=> boot_read_data == 16'h0000)
      else $error("locked boot data leaked");
   ready_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      !mem_status.eeprom_busy |=> ee_ready_flag_q)
      else $error("ready flag not set");
   irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ee_ready_en_q && ee_ready_flag_q) |=> eeprom_ready_irq)
      else $error("interrupt not raised");
   irq_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ee_ready_flag_q |=> !eeprom_ready_irq)
      else $error("interrupt without flag");
   busy_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 (ee_busy_q == $past(mem_status.eeprom_busy)) &&
      (flash_busy_q == $past(mem_status.flash_busy)))
      else $error("busy status stale");
   fault_last_a: assert property (@(posedge pclk) disable iff (!presetn)
      mem_status.op_done |=> write_fault_q == $past(mem_status.op_error))
      else $error("fault not from last op");
   flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == nvm_regs_pkg::int_flag_off && pstrb[0] && pwdata[0] &&
       mem_status.eeprom_busy) |=> !ee_ready_flag_q)
      else $error("flag not cleared");
   data_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == nvm_regs_pkg::data_off && pstrb[1:0] == 2'b11)
      |=> data_q == $past(pwdata[15:0]))
      else $error("data not stored");
   unused_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_en && paddr == nvm_regs_pkg::status_off) |=> prdata[31:3] == 29'h0)
      else $error("unused bits nonzero");
   err_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && !mapped(paddr))
      |=> pslverr && pready && prdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   lock_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      lock_armed |=> lock_armed)
      else $error("boot lock cleared without reset");
   lock_refused_a: assert property (@(posedge pclk) disable iff (!presetn)
      (lock_write && !boot_access.in_boot && !lock_armed) |=> !lock_armed)
      else $error("lock taken outside boot");
   active_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      lock_active |=> lock_active)
      else $error("active lock dropped");
   wp_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      app_wp_q |=> app_wp_q)
      else $error("write protect cleared");
   addr_track_a: assert property (@(posedge pclk) disable iff (!presetn)
      (app_write_req && !app_wp_q && !(wr_en && paddr == nvm_regs_pkg::addr_off))
      |=> addr_q == $past(app_write_addr))
      else $error("last address not tracked");
   blocked_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
      (app_write_req && app_wp_q && !mem_status.op_done) |=> write_fault_q)
      else $error("blocked write without fault");
   fault_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (app_write_req && !app_wp_q && !mem_status.op_done) |=> !write_fault_q)
      else $error("stale write fault");
   irq_prompt_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ee_ready_en_q && !mem_status.eeprom_busy &&
       !(wr_en && paddr == nvm_regs_pkg::int_enable_off)) |=> ##1 eeprom_ready_irq)
      else $error("idle request not raised");

   lock_cov_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(lock_active));
   irq_cov_c:  cover property (@(posedge pclk) disable iff (!presetn) $rose(eeprom_ready_irq));
   wp_cov_c:   cover property (@(posedge pclk) disable iff (!presetn) app_wp_q && app_write_req);
   irq_clr_c:  cover property (@(posedge pclk) disable iff (!presetn) $fell(eeprom_ready_irq));

endmodule
`default_nettype wire

// [nvm_array_model.sv]
// Behavioural model of the flash and EEPROM arrays behind the controller.
`timescale 1ns/1ps
`default_nettype none
module nvm_array_model
#(
   parameter int busy_cycles = 8
)
(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     ee_start,
   input  wire logic                     fl_start,
   input  wire logic                     fail,
   output var nvm_regs_pkg::mem_status_s mem_status
);
   int cnt_q;
   // A command keeps its array busy, then reports done with its error level.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= 0;
         mem_status <= '0;
      end
      else if (cnt_q == 0)
      begin
         mem_status.op_done <= 1'b0;
         if (ee_start || fl_start)
         begin
            cnt_q <= busy_cycles;
            mem_status.eeprom_busy <= ee_start;
            mem_status.flash_busy <= fl_start;
         end
      end
      else
      begin
         cnt_q <= cnt_q - 1;
         if (cnt_q == 1)
         begin
            mem_status <= '0;
            mem_status.op_done <= 1'b1;
            mem_status.op_error <= fail;
         end
      end
   end
endmodule
`default_nettype wire

// [nvm_protect_status_regs_tb.sv]
// Self-checking bench for the protection, status and interrupt register block.
`timescale 1ns/1ps
`default_nettype none
module nvm_protect_status_regs_tb;
   localparam logic [11:0] pr = nvm_regs_pkg::protect_off;
   localparam logic [11:0] st = nvm_regs_pkg::status_off;
   localparam logic [11:0] ie = nvm_regs_pkg::int_enable_off;
   localparam logic [11:0] fl = nvm_regs_pkg::int_flag_off;
   localparam logic [11:0] da = nvm_regs_pkg::data_off;
   localparam logic [11:0] ad = nvm_regs_pkg::addr_off;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdata;
   logic [3:0]  pstrb = '0;
   logic        pready, pslverr, rerr, app_write_block, irq;
   logic        app_write_req = 1'b0, ee_start = 1'b0, fl_start = 1'b0, fail = 1'b0;
   logic [15:0] app_write_addr = '0, boot_raw_data = '0, boot_read_data;
   nvm_regs_pkg::mem_status_s  mem_status;
   nvm_regs_pkg::boot_access_s boot_access = '0;
   int          bad_count = 0, tests_run = 0;

   always #25 pclk = ~pclk;

   nvm_protect_status_regs i_dut
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .mem_status, .boot_access, .app_write_req,
      .app_write_addr, .boot_raw_data, .boot_read_data, .app_write_block,
      .eeprom_ready_irq(irq)
   );

   nvm_array_model #(.busy_cycles(20)) i_mem
   (
      .pclk, .presetn, .ee_start, .fl_start, .fail, .mem_status
   );

   task automatic final_report();
      $display("tests run %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, '0, '0);
      chk(rdata, exp);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask

   task automatic app_wr(input logic [15:0] a);
      @(posedge pclk);
      app_write_addr <= a;
      app_write_req <= 1'b1;
      @(posedge pclk);
      app_write_req <= 1'b0;
   endtask

   task automatic boot(input logic f);
      @(posedge pclk);
      boot_access.boot_read <= !f;
      boot_access.boot_fetch <= f;
      @(posedge pclk);
      boot_access.boot_read <= 1'b0;
      boot_access.boot_fetch <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic t_reset();
      rd(pr, 32'h0);
      rd(st, 32'h0);
      rd(ie, 32'h0);
      rd(fl, 32'h1);
      rd(da, 32'h0);
      rd(ad, 32'h0);
      rd(12'h014, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      $display("reset test done");
   endtask

   task automatic t_data();
      wr(da, 32'h0000a5c3);
      apb(1'b1, da, 32'h00007e11, 4'h2);
      rd(da, 32'h00007ec3);
      wr(ad, 32'h00001234);
      rd(ad, 32'h00001234);
      $display("data test done");
   endtask

   task automatic t_busy();
      fail <= 1'b1;
      ee_start <= 1'b1;
      @(posedge pclk);
      ee_start <= 1'b0;
      rd(st, 32'h2);
      repeat (24) @(posedge pclk);
      rd(st, 32'h4);
      fail <= 1'b0;
      fl_start <= 1'b1;
      @(posedge pclk);
      fl_start <= 1'b0;
      rd(st, 32'h5);
      repeat (24) @(posedge pclk);
      rd(st, 32'h0);
      $display("busy test done");
   endtask

   task automatic t_irq();
      ee_start <= 1'b1;
      @(posedge pclk);
      ee_start <= 1'b0;
      wr(fl, 32'h1);
      rd(fl, 32'h0);
      wr(ie, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      repeat (24) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      wr(fl, 32'h1);
      rd(fl, 32'h1);
      wr(ie, 32'h0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      wr(ie, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      ee_start <= 1'b1;
      @(posedge pclk);
      ee_start <= 1'b0;
      chk({31'h0, irq}, 32'h1);
      wr(fl, 32'h1);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      wr(ie, 32'h0);
      repeat (24) @(posedge pclk);
      $display("interrupt test done");
   endtask

   task automatic t_protect();
      app_wr(16'h0456);
      rd(ad, 32'h00000456);
      wr(pr, 32'h000000fd);
      rd(pr, 32'h1);
      wr(pr, 32'h0);
      rd(pr, 32'h1);
      chk({31'h0, app_write_block}, 32'h1);
      app_wr(16'h0789);
      rd(st, 32'h4);
      rd(ad, 32'h00000456);
      $display("protect test done");
   endtask

   task automatic t_lock();
      boot_raw_data <= 16'hbeef;
      boot_access.in_boot <= 1'b1;
      wr(pr, 32'h2);
      rd(pr, 32'h3);
      boot(1'b0);
      chk({16'h0, boot_read_data}, 32'h0000beef);
      boot_access.in_boot <= 1'b0;
      repeat (2) @(posedge pclk);
      boot(1'b1);
      chk({16'h0, boot_read_data}, 32'h0);
      boot(1'b0);
      chk({16'h0, boot_read_data}, 32'h0);
      boot_access.in_boot <= 1'b1;
      wr(pr, 32'h0);
      rd(pr, 32'h3);
      boot_access.in_boot <= 1'b0;
      $display("lock test done");
   endtask

   task automatic t_rst();
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(pr, 32'h0);
      chk({31'h0, app_write_block}, 32'h0);
      rd(da, 32'h0);
      $display("second reset test done");
   endtask

   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_data();
      t_busy();
      t_irq();
      t_protect();
      t_lock();
      t_rst();
      final_report();
   end

   // The tests need well under a thousand cycles; this allows twenty thousand.
   initial
   begin
      #1000000;
      bad_count++;
      final_report();
   end
endmodule
`default_nettype wire
